// ### i2cms_chk.sv
// Port assertions of the I2C start and clock arbitration block
`timescale 1ns/1ps
module i2cms_chk (
   input logic        mclk_i,
   input logic        nrst_i,
   input logic        hsel_i,
   input logic [31:0] haddr_i,
   input logic [1:0]  htrans_i,
   input logic        hwrite_i,
   input logic        hready_i,
   input logic [31:0] hrdata_o,
   input logic        hreadyout_o,
   input logic        hresp_o,
   input logic        scl_i,
   input logic        scl_oe_o,
   input logic        sda_o,
   input logic        sda_oe_o,
   input logic        irq_o
);
   logic       wr_q;
   logic [7:0] wa_q;
   logic       cw, lw, rd;
   // Last accepted write and its address
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
         wa_q <= haddr_i[7:0];
      end
   end
   // Writes to control two and to the line register, and read requests
   assign cw = wr_q && wa_q == 8'h00;
   assign lw = wr_q && wa_q == 8'h18;
   assign rd = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_low_held;
      sda_oe_o [*2];
   endsequence
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not zero-wait OKAY");
   a_drive_low: assert property (!sda_o)
      else $error("data pin driven high");
   a_start_scl_high: assert property ($rose(sda_oe_o) |-> $past(scl_i, 3) && !scl_oe_o)
      else $error("data driven low while clock low");
   a_start_held: assert property ($rose(sda_oe_o) |-> s_low_held)
      else $error("data line not held after start");
   a_data_release: assert property ($fell(sda_oe_o) |-> $past(cw) || $past(cw, 2))
      else $error("data released without control write");
   a_clock_release: assert property ($changed(scl_oe_o) |-> $past(lw) || $past(lw, 2))
      else $error("clock drive changed without line write");
   a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata_o))
      else $error("read data changed without read");
   a_irq_clear: assert property ($fell(irq_o) |-> $past(wr_q) || $past(wr_q, 2))
      else $error("interrupt dropped without write");
endmodule
bind i2cms_core i2cms_chk i_chk (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_i(scl_i), .scl_oe_o(scl_oe_o),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// ### i2cms_core.v
// I2C master Start generation and clock arbitration with AHB-Lite registers
`timescale 1ns/1ps
`include "i2cms_map.vh"
module i2cms_core #(
   parameter RELOAD_W = 7
) (
   input  wire        mclk_i,
   input  wire        nrst_i,
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg  [31:0] hrdata_o,
   output reg         hreadyout_o,
   output reg         hresp_o,
   input  wire        scl_i,
   output reg         scl_o,
   output reg         scl_oe_o,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   output reg         irq_o
);

   // ----------------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------------
   localparam ST_IDLE  = 2'h0;
   localparam ST_WAIT1 = 2'h1;
   localparam ST_WAIT2 = 2'h2;
   localparam ST_HELD  = 2'h3;

   // ----------------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------------
   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   wire      scl_hi = scl_sync_q[1];
   wire      sda_hi = sda_sync_q[1];

   // Two flops per pin before any logic looks at it
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
      end
   end

   // ----------------------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------------------
   reg        wr_pend_q;
   reg [7:0]  wr_addr_q;
   reg [1:0]  state_q;
   reg [4:0]  ctrl2_low_q;
   reg [2:0]  ctrl2_high_q;
   reg [RELOAD_W-1:0] reload_q;
   reg [RELOAD_W-1:0] cnt_q;
   reg        cnt_run_q;
   reg        start_seen_q;
   reg        write_collision_flag_q;
   reg [7:0]  buf_q;
   reg [1:0]  irq_st_q;
   reg [1:0]  irq_msk_q;
   reg        line_rel_q;
   reg        scl_rel_seen_q;

   wire       take     = hsel_i & hready_i & htrans_i[1];
   wire       busy     = (state_q == ST_WAIT1) | (state_q == ST_WAIT2);
   wire       wr_ctrl2 = wr_pend_q & (wr_addr_q == `I2CMS_CTRL2_OFS);
   wire       wr_buf   = wr_pend_q & (wr_addr_q == `I2CMS_BUF_OFS);
   wire       tick     = cnt_run_q & (cnt_q == {RELOAD_W{1'b0}});
   reg        bcol_ev;
   reg        done_ev;

   // Read data mux, unmapped reads return zero
   reg [31:0] rd_mux;
   always @* begin
      case (haddr_i[7:0])
         `I2CMS_CTRL2_OFS:   rd_mux = {24'h000000, ctrl2_high_q, ctrl2_low_q};
         `I2CMS_STATUS_OFS:  rd_mux = {24'h000000, write_collision_flag_q, 3'h0, start_seen_q, 3'h0};
         `I2CMS_RELOAD_OFS:  rd_mux = {{(32-RELOAD_W){1'b0}}, reload_q};
         `I2CMS_BUF_OFS:     rd_mux = {24'h000000, buf_q};
         `I2CMS_IRQ_ST_OFS:  rd_mux = {30'h00000000, irq_st_q};
         `I2CMS_IRQ_MSK_OFS: rd_mux = {30'h00000000, irq_msk_q};
         `I2CMS_LINE_OFS:    rd_mux = {31'h00000000, line_rel_q};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   // Zero wait state slave: latch write address, present read data in data phase
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
         hrdata_o    <= 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         wr_pend_q <= take & hwrite_i;
         wr_addr_q <= haddr_i[7:0];
         if (take && !hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------------
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl2_high_q <= 3'h0;
         reload_q     <= `I2CMS_RELOAD_RST;
         buf_q        <= 8'h00;
         irq_msk_q    <= 2'h0;
         line_rel_q   <= 1'b1;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            `I2CMS_CTRL2_OFS:   ctrl2_high_q <= hwdata_i[7:5];
            `I2CMS_RELOAD_OFS:  reload_q     <= hwdata_i[RELOAD_W-1:0];
            `I2CMS_IRQ_MSK_OFS: irq_msk_q    <= hwdata_i[1:0];
            `I2CMS_LINE_OFS:    line_rel_q   <= hwdata_i[0];
            `I2CMS_BUF_OFS: begin
               if (!busy) begin
                  buf_q <= hwdata_i[7:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Write collision flag, hardware set wins over software clear
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         write_collision_flag_q <= 1'b0;
      end else if (wr_buf && busy) begin
         write_collision_flag_q <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == `I2CMS_STATUS_OFS && !hwdata_i[`I2CMS_WRITE_COLLISION_FLAG_BIT]) begin
         write_collision_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Rate counter
   // ----------------------------------------------------------------------------
   // Counts down from the reload value; zero gives a one-cycle tick
   reg cnt_load;
   reg cnt_stop;
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q     <= {RELOAD_W{1'b0}};
         cnt_run_q <= 1'b0;
      end else if (cnt_load) begin
         cnt_q     <= reload_q;
         cnt_run_q <= 1'b1;
      end else if (cnt_stop) begin
         cnt_run_q <= 1'b0;
      end else if (cnt_run_q) begin
         cnt_q <= (cnt_q == {RELOAD_W{1'b0}}) ? reload_q : cnt_q - 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Start sequencer and clock arbitration
   // ----------------------------------------------------------------------------
   reg [1:0] state_d;
   always @* begin
      state_d  = state_q;
      cnt_load = 1'b0;
      cnt_stop = 1'b0;
      bcol_ev  = 1'b0;
      done_ev  = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (ctrl2_low_q[`I2CMS_START_REQ_BIT] && !wr_ctrl2) begin
               if (!scl_hi && !sda_hi) begin
                  bcol_ev = 1'b1;
                  state_d = ST_IDLE;
               end else if (scl_hi && sda_hi) begin
                  cnt_load = 1'b1;
                  state_d  = ST_WAIT1;
               end else if (line_rel_q && scl_rel_seen_q) begin
                  cnt_load = 1'b1;
               end else begin
                  cnt_stop = 1'b1;
               end
            end else if (line_rel_q && !scl_hi) begin
               cnt_stop = 1'b1;
            end else if (line_rel_q && scl_rel_seen_q) begin
               cnt_load = 1'b1;
            end
         end
         ST_WAIT1: begin
            if (!scl_hi) begin
               bcol_ev  = 1'b1;
               cnt_stop = 1'b1;
               state_d  = ST_IDLE;
            end else if (tick) begin
               if (sda_hi) begin
                  cnt_load = 1'b1;
                  state_d  = ST_WAIT2;
               end else begin
                  bcol_ev  = 1'b1;
                  cnt_stop = 1'b1;
                  state_d  = ST_IDLE;
               end
            end
         end
         ST_WAIT2: begin
            if (tick) begin
               cnt_stop = 1'b1;
               done_ev  = 1'b1;
               state_d  = ST_HELD;
            end
         end
         ST_HELD: begin
            if (wr_ctrl2 && !hwdata_i[`I2CMS_START_REQ_BIT]) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // State, start request, start-seen and pin drive
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q        <= ST_IDLE;
         ctrl2_low_q    <= 5'h00;
         start_seen_q   <= 1'b0;
         scl_rel_seen_q <= 1'b0;
         sda_o          <= 1'b0;
         sda_oe_o       <= 1'b0;
         scl_o          <= 1'b0;
         scl_oe_o       <= 1'b0;
      end else begin
         state_q <= state_d;
         // Rising edge of released clock seen: one-shot reload trigger
         scl_rel_seen_q <= line_rel_q & scl_hi & ~scl_rel_seen_q & ~cnt_run_q;
         if (done_ev || bcol_ev) begin
            ctrl2_low_q[`I2CMS_START_REQ_BIT] <= 1'b0;
         end else if (wr_ctrl2 && !busy) begin
            ctrl2_low_q <= hwdata_i[`I2CMS_CTRL2_LOW_W-1:0];
         end
         if (state_q == ST_WAIT1 && state_d == ST_WAIT2) begin
            start_seen_q <= 1'b1;
         end else if (wr_pend_q && wr_addr_q == `I2CMS_STATUS_OFS
                      && !hwdata_i[`I2CMS_START_SEEN_BIT]) begin
            start_seen_q <= 1'b0;
         end
         sda_o    <= 1'b0;
         sda_oe_o <= (state_d == ST_WAIT2) | (state_d == ST_HELD);
         scl_o    <= 1'b0;
         scl_oe_o <= ~line_rel_q & (state_d == ST_IDLE);
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------------
   // Sticky events, write one to clear, set wins
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_st_q <= 2'h0;
         irq_o    <= 1'b0;
      end else begin
         irq_st_q <= (irq_st_q & ~((wr_pend_q && wr_addr_q == `I2CMS_IRQ_ST_OFS)
                                   ? hwdata_i[1:0] : 2'h0))
                     | {done_ev, bcol_ev};
         irq_o    <= |(irq_st_q & irq_msk_q);
      end
   end

endmodule

// ### i2cms_map.vh
// Register map, field positions and reset values of the I2C start and clock arbitration block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef I2CMS_MAP_VH
`define I2CMS_MAP_VH

// Byte offsets
`define I2CMS_CTRL2_OFS   8'h00
`define I2CMS_STATUS_OFS  8'h04
`define I2CMS_RELOAD_OFS  8'h08
`define I2CMS_BUF_OFS     8'h0C
`define I2CMS_IRQ_ST_OFS  8'h10
`define I2CMS_IRQ_MSK_OFS 8'h14
`define I2CMS_LINE_OFS    8'h18

// Field positions
`define I2CMS_START_REQ_BIT 0
`define I2CMS_START_SEEN_BIT 3
`define I2CMS_WRITE_COLLISION_FLAG_BIT      7
`define I2CMS_IRQ_BCOL_BIT  0
`define I2CMS_IRQ_DONE_BIT  1
`define I2CMS_LINE_REL_BIT  0

// Reset value and field width
`define I2CMS_RELOAD_RST 7'h09
`define I2CMS_CTRL2_LOW_W 5

`endif

// ### i2cms_slave.sv
// Model of the slave devices sharing the two-wire bus
`timescale 1ns/1ps
module i2cms_slave (
   input  logic scl_oe_i,
   input  logic sda_oe_i,
   input  logic stretch_i,
   input  logic hold_sda_i,
   input  logic run_clk_i,
   output logic scl_o,
   output logic sda_o
);
   logic lk = 1'b1;
   // Link clock of 400 ns, off phase, standing high outside frames
   initial begin
      #7;
      forever #200 lk = run_clk_i ? ~lk : 1'b1;
   end
   // Wired-AND lines with pull-ups; a slave may stretch or hold low
   assign scl_o = ~scl_oe_i & ~stretch_i & lk;
   assign sda_o = ~sda_oe_i & ~hold_sda_i;
endmodule

// ### i2cms_tb_top.sv
// Testbench of the I2C start and clock arbitration block
`timescale 1ns/1ps
module i2cms_tb_top;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        hsel   = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr  = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hready, hresp, scl, sda, scl_d, sda_d, scl_oe, sda_oe, irq;
   logic        stretch = 1'b0;
   logic        hold    = 1'b0;
   logic        run     = 1'b0;
   int          err_count, total_checks, cyc, t0, t1, r, n;
   // Clock and cycle count
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;
   i2cms_core i_i2cms_core (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .irq_o(irq));
   i2cms_slave i_i2cms_slave (
      .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .stretch_i(stretch), .hold_sda_i(hold),
      .run_clk_i(run), .scl_o(scl), .sda_o(sda));
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Single bus transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      @(posedge mclk_i);
      for (n = 0; n < 50 && hready !== 1'b1; n++)
         @(posedge mclk_i);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk_i);
      for (n = n; n < 50 && hready !== 1'b1; n++)
         @(posedge mclk_i);
      rd = hrdata;
      if (n >= 50) begin
         err_count++;
         test_done();
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      ahb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic await(ref logic s, input logic v);
      for (n = 0; n < 300 && s !== v; n++)
         @(posedge mclk_i);
      if (n >= 300) begin
         err_count++;
         test_done();
      end
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      rc(8'h00, 32'h0, "ctrl_rst");
      rc(8'h04, 32'h0, "stat_rst");
      rc(8'h08, 32'h9, "reload_rst");
      rc(8'h18, 32'h1, "line_rst");
      rc(8'h40, 32'h0, "unmapped");
      chk("pin_out_levels", 32'h0, {scl_d, sda_d});
      ahb(1'b1, 8'h18, 32'h0);
      // Clock drive follows the line register one edge later
      repeat (2) @(posedge mclk_i);
      chk("scl_held", 1'b0, scl);
      ahb(1'b1, 8'h18, 32'h1);
      ahb(1'b1, 8'h14, 32'h3);
      ahb(1'b1, 8'h0C, 32'h5A);
      for (int i = 0; i < 2; i++) begin
         r = i ? 20 : 6;
         ahb(1'b1, 8'h08, r);
         ahb(1'b1, 8'h00, 32'h1);
         t0 = cyc;
         repeat (3) @(posedge mclk_i);
         ahb(1'b1, 8'h00, 32'h0);
         ahb(1'b1, 8'h0C, 32'hA5);
         await(sda_oe, 1'b1);
         chk("start_delay", 1'b1, cyc - t0 > r && cyc - t0 <= r + 8);
         t1 = cyc;
         chk("scl_at_start", 1'b1, scl);
         await(irq, 1'b1);
         chk("done_delay", 1'b1, cyc - t1 > r && cyc - t1 <= r + 4);
         chk("data_held", 1'b1, sda_oe);
         rc(8'h00, 32'h0, "req_clear");
         rc(8'h04, 32'h88, "status");
         rc(8'h0C, 32'h5A, "buffer");
         rc(8'h10, 32'h2, "irq_done");
         ahb(1'b1, 8'h10, 32'h2);
         ahb(1'b1, 8'h00, 32'h0);
         ahb(1'b1, 8'h04, 32'h0);
         @(posedge mclk_i);
         chk("irq_clear", 1'b0, irq);
         chk("released", 1'b0, sda_oe);
      end
      // Collisions: link clock runs over the start, or both lines low
      for (int c = 0; c < 2; c++) begin
         hold    <= (c == 1);
         stretch <= (c == 1);
         ahb(1'b1, 8'h00, 32'h1);
         run <= (c == 0);
         await(irq, 1'b1);
         chk("no_start", 1'b0, sda_oe);
         rc(8'h10, 32'h1, "bus_coll");
         rc(8'h00, 32'h0, "aborted");
         run     <= 1'b0;
         hold    <= 1'b0;
         stretch <= 1'b0;
         ahb(1'b1, 8'h10, 32'h1);
      end
      test_done();
   end
endmodule
